// >>> msu_pkg.sv
// Purpose: Shared constants and types for the multiply-subtract unit.
// Assumes: 32-bit register port, 40-bit accumulators, 16-bit operands.
// Notes:   Register offsets are byte addresses on the register port.
package msu_pkg;
	localparam int ACC_W  = 40;
	localparam int DAT_W  = 16;
	localparam int OPD_W  = 17;
	localparam int ADDR_W = 8;
	localparam int BUS_W  = 32;
	localparam int NACC   = 4;

	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_ASEL = 8'h0C;
	localparam logic [7:0] OFS_ACCL = 8'h10;
	localparam logic [7:0] OFS_ACCH = 8'h14;
	localparam logic [7:0] OFS_TMP0 = 8'h20;
	localparam logic [7:0] OFS_TMP3 = 8'h2C;

	// Mode bit positions in the control register
	localparam int CB_FRACT = 0;
	localparam int CB_PSAT  = 1;
	localparam int CB_RNEAR = 2;
	localparam int CB_WIDE  = 3;
	localparam int CB_ASAT  = 4;
	localparam int CB_SXT   = 5;
	localparam int CB_LEGACY = 6;
	localparam int CTRL_W   = 7;
	localparam logic [6:0] CTRL_RST = 7'h20;

	// Arithmetic constants
	localparam logic [16:0] OPD_MOST_NEG = 17'h18000;
	localparam logic [34:0] PROD_SAT     = 35'h07FFFFFFF;
	localparam logic [41:0] RND_HALF     = 42'h00000008000;
	localparam logic [41:0] RND_MASK     = 42'h3FFFFFF0000;
	localparam logic [15:0] RND_TIE      = 16'h8000;
	localparam logic [39:0] SAT32_POS    = 40'h007FFFFFFF;
	localparam logic [39:0] SAT32_NEG    = 40'hFF80000000;
	localparam logic [39:0] SAT40_POS    = 40'h7FFFFFFFFF;
	localparam logic [39:0] SAT40_NEG    = 40'h8000000000;

	typedef enum logic [2:0] {
		FORM_ACC_TMP,
		FORM_MEM_COEF,
		FORM_MEM_ACC,
		FORM_TMP_MEM,
		FORM_DUAL
	} msu_form_t;
endpackage : msu_pkg

// >>> msu_core.sv
// Purpose: Single-cycle multiply-and-subtract datapath with register port.
// Assumes: Decoder and operand buses run on mclk_in; no input synchronisers.
// Notes:   Instruction issue beats a register write to the same target.
//
// Contract
// (RULE1) Register form: source acc bits 32..16 times temp, subtract from dest, one cycle.
// (RULE2) Memory-times-acc form: source acc bits 32..16 times sign-extended memory operand.
// (RULE3) Coefficient form: memory operand times coefficient, both sign-extended to 17 bits.
// (RULE4) Temp-times-memory form: both sign-extended, subtract from source, write dest.
// (RULE5) Dual form: both multiplier inputs from the two dual memory operands.
// (RULE6) Dual form: unsigned operand zero-extends, otherwise extension follows sign mode.
// (RULE7) Fractional mode shifts multiplier output left one bit.
// (RULE8) Product saturation mode governs multiplier overflow handling.
// (RULE9) Product sign-extended to 40 bits and subtracted from selected source.
// (RULE10) Round only when requested, method chosen by round mode.
// (RULE11) Overflow detected at chosen width sets destination overflow flag.
// (RULE12) Narrow mode checks overflow at bit 31, wide mode at 40 bits.
// (RULE13) On overflow saturate destination only if accumulator saturation enabled.
// (RULE14) Optional clause copies memory operand into third temp register.
// (RULE15) Dual form wide keyword forces wide mode for that instruction only.
// (RULE16) Coefficient comes from dedicated coefficient bus; software keeps it internal.
// (RULE17) Legacy mode with narrow overflow gives legacy-identical results.
// (RULE18) Every form repeats with identical behaviour per iteration.
// (RULE19) Default rounding adds 2^15 then clears bits 15..0.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module msu_core (
	input  wire logic              mclk_in,
	input  wire logic              rstn_in,
	input  wire logic [7:0]        reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [31:0]       reg_rdata_out,
	input  wire logic              op_valid_in,
	input  msu_pkg::msu_form_t     op_form_in,
	input  wire logic [1:0]        op_src_in,
	input  wire logic [1:0]        op_dst_in,
	input  wire logic [1:0]        op_tsel_in,
	input  wire logic              op_round_in,
	input  wire logic              op_uns_x_in,
	input  wire logic              op_uns_y_in,
	input  wire logic              op_wide_in,
	input  wire logic              op_t3_store_in,
	input  wire logic [15:0]       mem_x_in,
	input  wire logic [15:0]       mem_y_in,
	input  wire logic [15:0]       coef_bus_data_in,
	output logic      [39:0]       result_out,
	output logic      [1:0]        result_dst_out,
	output logic                   result_valid_out,
	output logic                   overflow_out,
	output logic      [15:0]       third_temp_register_out,
	output logic      [3:0]        dest_accum_overflow_flag_out,
	output logic                   irq_out
);
	import msu_pkg::*;

	function automatic logic [16:0] ext17(input logic [15:0] d, input logic sx);
		ext17 = sx ? {d[15], d} : {1'b0, d};
	endfunction : ext17

	function automatic logic [16:0] acc_hi17(input logic [39:0] a);
		acc_hi17 = a[32:16];
	endfunction : acc_hi17

	logic [39:0]        acc_q [NACC];
	logic [15:0]        tmp_q [NACC];
	logic [CTRL_W-1:0]  ctrl_q;
	logic [3:0]         stat_q;
	logic [3:0]         mask_q;
	logic [1:0]         asel_q;

	wire logic fractional_mode       = ctrl_q[CB_FRACT];
	wire logic product_saturate_mode = ctrl_q[CB_PSAT];
	wire logic round_nearest_mode    = ctrl_q[CB_RNEAR];
	wire logic wide_overflow_mode    = ctrl_q[CB_WIDE];
	wire logic accum_saturate_mode   = ctrl_q[CB_ASAT];
	wire logic sign_extend_mode      = ctrl_q[CB_SXT];

	logic [16:0]        opd_a;
	logic [16:0]        opd_b;
	logic [39:0]        minuend;
	logic signed [33:0] prod;
	logic [34:0]        prod_sh;
	logic [34:0]        prod_fin;
	logic [41:0]        diff;
	logic [41:0]        rounded;
	logic               wide_eff;
	logic               ovf;
	logic [39:0]        res;

	// Operand selection; no state carried between ops, so repeats behave alike
	always_comb begin // RULE18
		opd_a   = '0;
		opd_b   = '0;
		minuend = acc_q[op_dst_in];
		unique case (op_form_in)
			FORM_ACC_TMP: begin
				opd_a   = acc_hi17(acc_q[op_src_in]); // RULE1
				opd_b   = ext17(tmp_q[op_tsel_in], 1'b1);
				minuend = acc_q[op_dst_in];
			end
			FORM_MEM_COEF: begin
				opd_a   = ext17(mem_x_in, 1'b1); // RULE3
				opd_b   = ext17(coef_bus_data_in, 1'b1); // RULE16
				minuend = acc_q[op_dst_in];
			end
			FORM_MEM_ACC: begin
				opd_a   = acc_hi17(acc_q[op_src_in]); // RULE2
				opd_b   = ext17(mem_x_in, 1'b1);
				minuend = acc_q[op_dst_in];
			end
			FORM_TMP_MEM: begin
				opd_a   = ext17(tmp_q[op_tsel_in], 1'b1); // RULE4
				opd_b   = ext17(mem_x_in, 1'b1);
				minuend = acc_q[op_src_in];
			end
			FORM_DUAL: begin
				opd_a   = ext17(mem_x_in, !op_uns_x_in && sign_extend_mode); // RULE5 RULE6
				opd_b   = ext17(mem_y_in, !op_uns_y_in && sign_extend_mode); // RULE6
				minuend = acc_q[op_src_in];
			end
			default: begin
				opd_a   = '0;
				opd_b   = '0;
			end
		endcase
	end

	// Product stage
	always_comb begin
		prod     = $signed(opd_a) * $signed(opd_b);
		prod_sh  = fractional_mode ? {prod, 1'b0} : {prod[33], prod}; // RULE7
		prod_fin = prod_sh;
		// Only -1.0 x -1.0 in fractional mode is clamped; other out-of-range products pass unclamped
		if (product_saturate_mode && fractional_mode
			&& opd_a == OPD_MOST_NEG && opd_b == OPD_MOST_NEG) begin
			prod_fin = PROD_SAT; // RULE8
		end
	end

	// Subtract, round, overflow, saturate; two guard bits keep the true sign
	always_comb begin
		diff = {{2{minuend[39]}}, minuend} - {{7{prod_fin[34]}}, prod_fin}; // RULE9
		rounded = diff;
		if (op_round_in) begin // RULE10
			rounded = (diff + RND_HALF) & RND_MASK; // RULE19
			if (round_nearest_mode && diff[15:0] == RND_TIE) begin
				rounded[16] = 1'b0;
			end
		end
		wide_eff = wide_overflow_mode || (op_form_in == FORM_DUAL && op_wide_in); // RULE15
		if (wide_eff) begin
			ovf = !(&rounded[41:39] || !(|rounded[41:39])); // RULE12
		end else begin
			// Narrow mode matches legacy arithmetic exactly
			ovf = !(&rounded[41:31] || !(|rounded[41:31])); // RULE12 RULE17
		end
		res = rounded[39:0];
		if (ovf && accum_saturate_mode) begin // RULE13
			if (wide_eff) begin
				res = rounded[41] ? SAT40_NEG : SAT40_POS;
			end else begin
				res = rounded[41] ? SAT32_NEG : SAT32_POS;
			end
		end
	end

	wire logic wr_ctrl = reg_wr_in && reg_addr_in == OFS_CTRL;
	wire logic wr_stat = reg_wr_in && reg_addr_in == OFS_STAT;
	wire logic wr_mask = reg_wr_in && reg_addr_in == OFS_MASK;
	wire logic wr_asel = reg_wr_in && reg_addr_in == OFS_ASEL;
	wire logic wr_accl = reg_wr_in && reg_addr_in == OFS_ACCL;
	wire logic wr_acch = reg_wr_in && reg_addr_in == OFS_ACCH;
	wire logic wr_tmp  = reg_wr_in && reg_addr_in >= OFS_TMP0
		&& reg_addr_in <= OFS_TMP3 && reg_addr_in[1:0] == 2'h0;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_q <= CTRL_RST;
			mask_q <= 4'h0;
			asel_q <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata_in[CTRL_W-1:0];
			end
			if (wr_mask) begin
				mask_q <= reg_wdata_in[3:0];
			end
			if (wr_asel) begin
				asel_q <= reg_wdata_in[1:0];
			end
		end
	end

	// Accumulators: issue wins over a register write in the same cycle
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NACC; i++) begin
				acc_q[i] <= 40'h0000000000;
			end
		end else begin
			if (wr_accl) begin
				acc_q[asel_q][31:0] <= reg_wdata_in;
			end
			if (wr_acch) begin
				acc_q[asel_q][39:32] <= reg_wdata_in[7:0];
			end
			if (op_valid_in) begin
				acc_q[op_dst_in] <= res; // RULE1
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NACC; i++) begin
				tmp_q[i] <= 16'h0000;
			end
		end else begin
			if (wr_tmp) begin
				tmp_q[reg_addr_in[3:2]] <= reg_wdata_in[15:0];
			end
			if (op_valid_in && op_t3_store_in) begin
				tmp_q[3] <= mem_x_in; // RULE14
			end
		end
	end

	// Sticky flags: a new overflow beats a write-one-to-clear
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stat_q <= 4'h0;
		end else begin
			for (int i = 0; i < NACC; i++) begin
				if (op_valid_in && ovf && op_dst_in == i[1:0]) begin
					stat_q[i] <= 1'b1; // RULE11
				end else if (wr_stat && reg_wdata_in[i]) begin
					stat_q[i] <= 1'b0;
				end
			end
		end
	end

	logic [3:0] stat_d;
	always_comb begin
		stat_d = stat_q;
		for (int i = 0; i < NACC; i++) begin
			if (op_valid_in && ovf && op_dst_in == i[1:0]) begin
				stat_d[i] = 1'b1;
			end else if (wr_stat && reg_wdata_in[i]) begin
				stat_d[i] = 1'b0;
			end
		end
	end

	// Interrupt follows the next flag state so it lines up with the flags
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(stat_d & (wr_mask ? reg_wdata_in[3:0] : mask_q));
		end
	end

	always_comb begin
		dest_accum_overflow_flag_out = stat_q;
		third_temp_register_out      = tmp_q[3];
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			result_out       <= 40'h0000000000;
			result_dst_out   <= 2'h0;
			result_valid_out <= 1'b0;
			overflow_out     <= 1'b0;
		end else begin
			result_valid_out <= op_valid_in;
			overflow_out     <= op_valid_in && ovf; // RULE11
			if (op_valid_in) begin
				result_out     <= res;
				result_dst_out <= op_dst_in;
			end
		end
	end

	// Read data valid in the cycle after the read strobe only
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (!reg_rd_in) begin
			reg_rdata_out <= 32'h00000000;
		end else begin
			unique case (reg_addr_in)
				OFS_CTRL: reg_rdata_out <= {25'h0000000, ctrl_q};
				OFS_STAT: reg_rdata_out <= {28'h0000000, stat_q};
				OFS_MASK: reg_rdata_out <= {28'h0000000, mask_q};
				OFS_ASEL: reg_rdata_out <= {30'h00000000, asel_q};
				OFS_ACCL: reg_rdata_out <= acc_q[asel_q][31:0];
				OFS_ACCH: reg_rdata_out <= {24'h000000, acc_q[asel_q][39:32]};
				8'h20:    reg_rdata_out <= {16'h0000, tmp_q[0]};
				8'h24:    reg_rdata_out <= {16'h0000, tmp_q[1]};
				8'h28:    reg_rdata_out <= {16'h0000, tmp_q[2]};
				OFS_TMP3: reg_rdata_out <= {16'h0000, tmp_q[3]};
				default:  reg_rdata_out <= 32'h00000000;
			endcase
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	chk_result_one_cycle: assert property ( // RULE1
		op_valid_in |=> result_valid_out && result_out == $past(res)
			&& acc_q[$past(op_dst_in)] == $past(res))
		else $error("result not written one cycle after issue");

	chk_acc_hi_operand: assert property ( // RULE2
		op_form_in == FORM_MEM_ACC |-> opd_a == acc_q[op_src_in][32:16]
			&& opd_b == {mem_x_in[15], mem_x_in})
		else $error("memory times accumulator operands wrong");

	chk_coef_operand: assert property ( // RULE3
		op_form_in == FORM_MEM_COEF |-> opd_b == {coef_bus_data_in[15], coef_bus_data_in})
		else $error("coefficient operand not sign-extended bus value");

	chk_dual_unsigned: assert property ( // RULE6
		op_form_in == FORM_DUAL && op_uns_x_in |-> opd_a[16] == 1'b0)
		else $error("unsigned dual operand not zero-extended");

	chk_fract_shift: assert property ( // RULE7
		fractional_mode && !product_saturate_mode |-> prod_fin[0] == 1'b0)
		else $error("fractional shift missing");

	chk_ovf_flag_set: assert property ( // RULE11
		op_valid_in && ovf |=> stat_q[$past(op_dst_in)] && overflow_out)
		else $error("overflow flag not set");

	chk_sat_narrow: assert property ( // RULE13
		ovf && accum_saturate_mode && !wide_eff |-> res == SAT32_POS || res == SAT32_NEG)
		else $error("narrow saturation value wrong");

	chk_t3_store: assert property ( // RULE14
		op_valid_in && op_t3_store_in |=> third_temp_register_out == $past(mem_x_in))
		else $error("third temp register not loaded");

	chk_wide_local: assert property ( // RULE15
		op_form_in == FORM_DUAL && op_wide_in |-> wide_eff ##1 $stable(ctrl_q) || $past(wr_ctrl))
		else $error("wide keyword not applied locally");

	chk_round_clear: assert property ( // RULE19
		op_round_in && !round_nearest_mode |-> rounded[15:0] == 16'h0000)
		else $error("rounding left low bits set");

	chk_sat_wide: assert property ( // RULE13
		ovf && accum_saturate_mode && wide_eff |-> res == SAT40_POS || res == SAT40_NEG)
		else $error("wide saturation value wrong");

	chk_acc_tmp_operands: assert property ( // RULE1
		op_form_in == FORM_ACC_TMP |-> opd_a == acc_q[op_src_in][32:16]
			&& opd_b == {tmp_q[op_tsel_in][15], tmp_q[op_tsel_in]})
		else $error("register form operands wrong");

	chk_tmp_mem_operands: assert property ( // RULE4
		op_form_in == FORM_TMP_MEM |-> opd_a == {tmp_q[op_tsel_in][15], tmp_q[op_tsel_in]}
			&& opd_b == {mem_x_in[15], mem_x_in})
		else $error("temp times memory operands wrong");

	chk_no_round: assert property ( // RULE10
		!op_round_in |-> rounded == diff)
		else $error("result rounded without request");

	chk_narrow_fit: assert property ( // RULE12
		!wide_eff && !ovf |-> res[39:31] == {9{res[31]}})
		else $error("narrow result outside 32-bit range without overflow");

	chk_irq_level: assert property ( // RULE11
		irq_out == |(stat_q & mask_q))
		else $error("interrupt level does not follow masked flags");
endmodule : msu_core

// >>> msu_dec_model.sv
// Purpose: Decoder and operand bus stand-in for the multiply-subtract unit.
// Assumes: Bench calls issue; fields change just after a rising edge.
// Notes:   Released buses show inverted data, so stale values never match.
`timescale 1ns/1ns
module msu_dec_model
	import msu_pkg::*;
(
	input  wire logic   mclk_in,
	output logic        op_valid_out,
	output msu_form_t   op_form_out,
	output logic [1:0]  op_src_out,
	output logic [1:0]  op_dst_out,
	output logic [1:0]  op_tsel_out,
	output logic        op_round_out,
	output logic        op_uns_x_out,
	output logic        op_uns_y_out,
	output logic        op_wide_out,
	output logic        op_t3_out,
	output logic [15:0] mem_x_out,
	output logic [15:0] mem_y_out,
	output logic [15:0] coef_out
);
	initial begin
		op_valid_out = 1'b0;
		op_form_out = FORM_ACC_TMP;
		{op_src_out, op_dst_out, op_tsel_out} = 6'h00;
		{op_round_out, op_uns_x_out, op_uns_y_out, op_wide_out, op_t3_out} = 5'h00;
		{mem_x_out, mem_y_out, coef_out} = 48'h0;
	end

	// Flags k: round, unsigned x, unsigned y, wide, temp 3 store
	task automatic issue(input msu_form_t f, input logic [1:0] s, d, t,
		input logic [4:0] k, input logic [15:0] x, y, c, input int n);
		repeat (n) begin
			@(posedge mclk_in);
			op_valid_out <= 1'b1;
			op_form_out <= f;
			op_src_out <= s;
			op_dst_out <= d;
			op_tsel_out <= t;
			{op_round_out, op_uns_x_out, op_uns_y_out, op_wide_out, op_t3_out} <= k;
			mem_x_out <= x;
			mem_y_out <= y;
			coef_out <= c;
		end
		@(posedge mclk_in);
		op_valid_out <= 1'b0;
		mem_x_out <= ~x;
		mem_y_out <= ~y;
		coef_out <= ~c;
	endtask : issue
endmodule : msu_dec_model

// >>> tb_top.sv
// Purpose: Self-checking bench for the multiply-subtract unit.
// Assumes: Expected values worked by hand from the arithmetic rules.
// Notes:   Register port driven directly; ops come from the decoder model.
`timescale 1ns/1ns
module tb_top;
	import msu_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [31:0] rdata;
	logic        vld, rnd, ux, uy, wide, t3, res_vld, ovf, irq;
	msu_form_t   form;
	logic [1:0]  src, dst, tsel, res_dst;
	logic [15:0] mx, my, cf, t3_val;
	logic [39:0] res;
	logic [3:0]  flags;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	always #5 mclk_in = ~mclk_in;

	msu_dec_model msu_dec_model_inst (.mclk_in(mclk_in), .op_valid_out(vld),
		.op_form_out(form), .op_src_out(src), .op_dst_out(dst), .op_tsel_out(tsel),
		.op_round_out(rnd), .op_uns_x_out(ux), .op_uns_y_out(uy), .op_wide_out(wide),
		.op_t3_out(t3), .mem_x_out(mx), .mem_y_out(my), .coef_out(cf));

	msu_core msu_core_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(rdata), .op_valid_in(vld), .op_form_in(form), .op_src_in(src),
		.op_dst_in(dst), .op_tsel_in(tsel), .op_round_in(rnd), .op_uns_x_in(ux),
		.op_uns_y_in(uy), .op_wide_in(wide), .op_t3_store_in(t3), .mem_x_in(mx),
		.mem_y_in(my), .coef_bus_data_in(cf), .result_out(res), .result_dst_out(res_dst),
		.result_valid_out(res_vld), .overflow_out(ovf), .third_temp_register_out(t3_val),
		.dest_accum_overflow_flag_out(flags), .irq_out(irq));

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	task automatic chk(input logic [39:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		@(negedge mclk_in);
		chk(rdata, e);
	endtask : rd

	task automatic ctl(input logic [7:0] v);
		wr(OFS_CTRL, {24'h0, v});
	endtask : ctl

	task automatic setacc(input logic [1:0] i, input logic [39:0] v);
		wr(OFS_ASEL, {30'h0, i});
		wr(OFS_ACCL, v[31:0]);
		wr(OFS_ACCH, {24'h0, v[39:32]});
	endtask : setacc

	task automatic getacc(input logic [1:0] i, input logic [39:0] e);
		wr(OFS_ASEL, {30'h0, i});
		rd(OFS_ACCL, e[31:0]);
		rd(OFS_ACCH, {24'h0, e[39:32]});
	endtask : getacc

	task automatic op(input msu_form_t f, input logic [1:0] s, d, t, input logic [4:0] k,
		input logic [15:0] x, y, c, input logic [39:0] e, input logic v);
		msu_dec_model_inst.issue(f, s, d, t, k, x, y, c, 1);
		@(negedge mclk_in);
		chk(res_vld, 1'b1);
		chk(res_dst, d);
		chk(res, e);
		chk(ovf, v);
	endtask : op

	task automatic t_reset;
		chk(res, 40'h0);
		rd(OFS_CTRL, 32'h20);
		rd(OFS_STAT, 32'h0);
		rd(8'h3C, 32'h0);
	endtask : t_reset

	// Same figures with legacy mode on, since narrow overflow must match
	task automatic t_acc_tmp;
		for (int i = 0; i < 2; i++) begin
			ctl(i ? 8'h60 : 8'h20);
			setacc(0, 40'h00EC000000);
			setacc(1, 40'h0034000000);
			wr(OFS_TMP0 + 8'h04, 32'h2000);
			op(FORM_ACC_TMP, 0, 1, 1, 5'h10, 0, 0, 0, 40'h0016800000, 0);
			getacc(1, 40'h0016800000);
		end
	endtask : t_acc_tmp

	task automatic t_coef;
		ctl(8'h20);
		setacc(2, 40'h00EC000000);
		op(FORM_MEM_COEF, 0, 2, 0, 5'h11, 16'hFE00, 0, 16'h0040, 40'h00EC010000, 1);
		chk(t3_val, 16'hFE00);
		chk(flags, 4'h4);
		ctl(8'h28);
		setacc(2, 40'h00EC000000);
		op(FORM_MEM_COEF, 0, 2, 0, 5'h10, 16'hFE00, 0, 16'h0040, 40'h00EC010000, 0);
		ctl(8'h30);
		setacc(2, 40'h00EC000000);
		op(FORM_MEM_COEF, 0, 2, 0, 5'h10, 16'hFE00, 0, 16'h0040, 40'h007FFFFFFF, 1);
		// Wide mode with saturation clamps at the full accumulator range
		ctl(8'h38);
		setacc(2, 40'h7FFFFFFFFF);
		op(FORM_MEM_COEF, 0, 2, 0, 5'h00, 16'hFFFF, 0, 16'h0001, 40'h7FFFFFFFFF, 1);
		wr(OFS_MASK, 32'h4);
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
		chk(irq, 1'b1);
		wr(OFS_STAT, 32'h4);
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
		chk(irq, 1'b0);
		rd(OFS_STAT, 32'h0);
	endtask : t_coef

	// Bit 32 set makes the 17-bit source slice negative
	task automatic t_mem_forms;
		ctl(8'h20);
		setacc(0, 40'h0100000000);
		setacc(1, 40'h0);
		op(FORM_MEM_ACC, 0, 1, 0, 0, 16'h0002, 0, 0, 40'h0000020000, 0);
		wr(OFS_TMP0, 32'hFFFF);
		setacc(2, 40'h5);
		op(FORM_TMP_MEM, 2, 3, 0, 0, 16'h0003, 0, 0, 40'h8, 0);
		getacc(2, 40'h5);
	endtask : t_mem_forms

	task automatic t_dual;
		setacc(0, 40'h0);
		op(FORM_DUAL, 0, 1, 0, 5'h0C, 16'hFFFF, 16'hFFFF, 0, 40'hFF0001FFFF, 1);
		op(FORM_DUAL, 0, 1, 0, 5'h0E, 16'hFFFF, 16'hFFFF, 0, 40'hFF0001FFFF, 0);
		rd(OFS_CTRL, 32'h20);
		op(FORM_DUAL, 0, 1, 0, 5'h08, 16'hFFFF, 16'hFFFF, 0, 40'h000000FFFF, 0);
		op(FORM_DUAL, 0, 1, 0, 5'h00, 16'hFFFF, 16'hFFFF, 0, 40'hFFFFFFFFFF, 0);
		ctl(8'h00);
		op(FORM_DUAL, 0, 1, 0, 5'h00, 16'hFFFF, 16'hFFFF, 0, 40'hFF0001FFFF, 1);
	endtask : t_dual

	task automatic t_fract;
		ctl(8'h23);
		setacc(0, 40'h0180000000);
		setacc(1, 40'h0);
		wr(OFS_TMP0 + 8'h08, 32'h8000);
		op(FORM_ACC_TMP, 0, 1, 2, 0, 0, 0, 0, 40'hFF80000001, 0);
		ctl(8'h21);
		setacc(1, 40'h0);
		op(FORM_ACC_TMP, 0, 1, 2, 0, 0, 0, 0, 40'hFF80000000, 0);
		setacc(0, 40'h0000030000);
		setacc(1, 40'h0);
		wr(OFS_TMP0 + 8'h08, 32'h2);
		op(FORM_ACC_TMP, 0, 1, 2, 0, 0, 0, 0, 40'hFFFFFFFFF4, 0);
	endtask : t_fract

	// Exact tie separates the two rounding methods
	task automatic t_round;
		ctl(8'h20);
		setacc(0, 40'h8000);
		op(FORM_MEM_COEF, 0, 0, 0, 5'h00, 0, 0, 0, 40'h8000, 0);
		op(FORM_MEM_COEF, 0, 0, 0, 5'h10, 0, 0, 0, 40'h10000, 0);
		ctl(8'h24);
		setacc(0, 40'h8000);
		op(FORM_MEM_COEF, 0, 0, 0, 5'h10, 0, 0, 0, 40'h0, 0);
	endtask : t_round

	task automatic t_repeat;
		ctl(8'h20);
		setacc(0, 40'h0000010000);
		setacc(1, 40'hA);
		wr(OFS_TMP0 + 8'h04, 32'h1);
		msu_dec_model_inst.issue(FORM_ACC_TMP, 0, 1, 1, 0, 0, 0, 0, 2);
		@(negedge mclk_in);
		chk(res_vld, 1'b1);
		chk(res, 40'h8);
		getacc(1, 40'h8);
	endtask : t_repeat

	initial begin
		repeat (8) @(posedge mclk_in);
		rstn_in <= 1'b1;
		t_reset();
		t_acc_tmp();
		t_coef();
		t_mem_forms();
		t_dual();
		t_fract();
		t_round();
		t_repeat();
		results();
	end

	// Run needs well under 2000 cycles
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
endmodule : tb_top
